// ---- ifvu_top.sv ----
// Interrupt flags, arbitration, vectoring and PC save for the core.
`timescale 1ns/10ps
module ifvu_top import ifvu_pkg::*; (
  input  wire logic            clk_sys_i,          // System clock, 40 MHz.
  input  wire logic            resetn_i,           // Synchronous reset, active low.
  input  wire logic            ext_pin0_n_i,       // External pin 0, active low.
  input  wire logic            ext_pin1_n_i,       // External pin 1, active low.
  input  wire logic            ext0_edge_select_i, // Pin 0 falling-edge mode.
  input  wire logic            ext1_edge_select_i, // Pin 1 falling-edge mode.
  input  wire logic            core_shutdown_mode_i, // Core shut down.
  input  wire logic            ext0_wake_i,        // Wake event on pin 0.
  input  wire logic            ext1_wake_i,        // Wake event on pin 1.
  input  wire logic            timer0_ovf_i,       // Timer 0 overflow pulse.
  input  wire logic            timer1_ovf_i,       // Timer 1 overflow pulse.
  input  wire logic            timer2_ovf_i,       // Timer 2 overflow pulse.
  input  wire logic            timer2_cap_i,       // Timer 2 external pulse.
  input  wire logic            power_evt_i,        // Power supply event pulse.
  input  wire logic            energy_evt_i,       // Energy DSP event pulse.
  input  wire logic            rtc_alarm_i,        // RTC alarm pulse.
  input  wire logic            rtc_interval_i,     // RTC interval pulse.
  input  wire logic            watchdog_evt_i,     // Watchdog timeout pulse.
  input  wire logic            temp_evt_i,         // Temperature ADC pulse.
  input  wire logic            spi_i2c_evt_i,      // SPI/I2C pulse.
  input  wire logic            uart_send_done_i,   // UART send flag level.
  input  wire logic            uart_recv_full_i,   // UART receive flag level.
  input  wire logic            uart2_send_done_i,  // UART2 send flag level.
  input  wire logic            uart2_recv_full_i,  // UART2 receive flag level.
  input  wire logic [7:0]      timer_ctrl_clr_i,   // Clear mask, timer control.
  input  wire logic [7:0]      timer2_ctrl_clr_i,  // Clear mask, timer 2 control.
  input  wire logic [7:0]      rtc_ctrl_clr_i,     // Clear mask, RTC control.
  input  wire logic            energy_clr_i,       // Clear energy bit.
  input  wire logic            power_clr_i,        // Clear power flag.
  input  wire logic            watchdog_clr_i,     // Clear watchdog flag.
  input  wire logic            global_enable_i,    // Master enable.
  input  wire logic [NSRC-1:0] src_enable_i,       // Enables, polling order.
  input  wire logic [NSRC-1:0] src_prio_hi_i,      // High level, polling order.
  input  wire logic            inst_done_i,        // Instruction boundary pulse.
  input  wire logic            return_from_isr_i,  // Return instruction pulse.
  input  wire logic            prio_en_access_i,   // Enable or priority access.
  input  wire logic [PC_W-1:0] pc_i,               // Current program counter.
  output logic [7:0]           timer_ctrl_reg_o,   // Timer control flags.
  output logic [7:0]           timer2_ctrl_reg_o,  // Timer 2 control flags.
  output logic [7:0]           rtc_ctrl_reg_o,     // RTC control flags.
  output logic [7:0]           energy_status_low_o, // Energy status low byte.
  output logic [7:0]           power_flag_reg_o,   // Power flag byte.
  output logic [7:0]           watchdog_ctrl_reg_o, // Watchdog flag byte.
  output logic                 push_pc_o,          // PC saved this cycle.
  output logic                 load_pc_o,          // Load vector into PC.
  output logic [PC_W-1:0]      vec_addr_o,         // Vector address.
  output logic                 pop_pc_o,           // Restore PC this cycle.
  output logic [PC_W-1:0]      pc_ret_o,           // Restored PC.
  output logic [2:0]           in_service_o        // Active levels, low to PSM.
);
  ifvu_arb_if arb ();

  ifvu_state_t     state;
  logic [3:0]      idx_q;
  logic [7:0]      lat_cnt;
  logic            blocked;
  logic [1:0]      sp;
  logic [PC_W-1:0] stack [STK_D];
  logic [PC_W-1:0] top_pc;
  logic [NSRC-1:0] ack;
  logic [NSRC-1:0] raw;
  logic            go;
  logic t0f, t1f, t2ovf, t2cap, psf, enf, alm, itv, wdf;
  logic temp_pend, spi_pend;
  logic ext0_flag, ext1_flag, ext0_req, ext1_req;

  // Set wins over clear so an event in the clearing cycle is kept.
  function automatic logic upd(input logic f, input logic s, input logic c);
    upd = s | (f & ~c);
  endfunction : upd

  // One-hot acknowledge to the source whose vector is being loaded.
  assign ack = (state == ST_LOAD) ? (NSRC'(1) << idx_q) : '0;

  ifvu_ext_unit u_ext0 (
    .clk_sys_i  (clk_sys_i),
    .resetn_i   (resetn_i),
    .pin_n_i    (ext_pin0_n_i),
    .edge_sel_i (ext0_edge_select_i),
    .shutdown_i (core_shutdown_mode_i),
    .wake_i     (ext0_wake_i),
    .ack_i      (ack[SRC_EXT0]),
    .sw_clr_i   (timer_ctrl_clr_i[TIMER_CTRL_REG_EXT0_BIT]),
    .flag_o     (ext0_flag),
    .req_o      (ext0_req)
  );

  ifvu_ext_unit u_ext1 (
    .clk_sys_i  (clk_sys_i),
    .resetn_i   (resetn_i),
    .pin_n_i    (ext_pin1_n_i),
    .edge_sel_i (ext1_edge_select_i),
    .shutdown_i (core_shutdown_mode_i),
    .wake_i     (ext1_wake_i),
    .ack_i      (ack[SRC_EXT1]),
    .sw_clr_i   (timer_ctrl_clr_i[TIMER_CTRL_REG_EXT1_BIT]),
    .flag_o     (ext1_flag),
    .req_o      (ext1_req)
  );

  // Timer 0 and 1 flags; each vector serves one source, so it clears it.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      t0f <= FLAG_RST;
      t1f <= FLAG_RST;
    end else begin
      t0f <= upd(t0f, timer0_ovf_i, timer_ctrl_clr_i[TIMER_CTRL_REG_T0_BIT] | ack[SRC_T0]);
      t1f <= upd(t1f, timer1_ovf_i, timer_ctrl_clr_i[TIMER_CTRL_REG_T1_BIT] | ack[SRC_T1]);
    end
  end

  // Flags that vectoring leaves set; software must find and clear the cause itself.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      t2ovf <= FLAG_RST;
      t2cap <= FLAG_RST;
      psf   <= FLAG_RST;
      enf   <= FLAG_RST;
      wdf   <= FLAG_RST;
    end else begin
      t2ovf <= upd(t2ovf, timer2_ovf_i, timer2_ctrl_clr_i[T2_OVF_BIT]);
      t2cap <= upd(t2cap, timer2_cap_i, timer2_ctrl_clr_i[T2_CAP_BIT]);
      psf   <= upd(psf, power_evt_i, power_clr_i);
      enf   <= upd(enf, energy_evt_i, energy_clr_i);
      wdf   <= upd(wdf, watchdog_evt_i, watchdog_clr_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      alm <= FLAG_RST;
      itv <= FLAG_RST;
    end else begin
      alm <= upd(alm, rtc_alarm_i, rtc_ctrl_clr_i[RTC_ALM_BIT]);
      itv <= upd(itv, rtc_interval_i, rtc_ctrl_clr_i[RTC_INT_BIT]);
    end
  end

  // Hidden latches: no software path clears them, only entering the routine.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      temp_pend <= FLAG_RST;
      spi_pend  <= FLAG_RST;
    end else begin
      temp_pend <= upd(temp_pend, temp_evt_i, ack[SRC_TEMP]);
      spi_pend  <= upd(spi_pend, spi_i2c_evt_i, ack[SRC_SPI]);
    end
  end

  // Raw requests in polling order.
  always_comb begin
    raw            = '0;
    raw[SRC_PSM]   = psf;
    raw[SRC_RTC]   = alm | itv;
    raw[SRC_EN]    = enf;
    raw[SRC_WDT]   = wdf;
    raw[SRC_TEMP]  = temp_pend;
    raw[SRC_EXT0]  = ext0_req;
    raw[SRC_T0]    = t0f;
    raw[SRC_EXT1]  = ext1_req;
    raw[SRC_T1]    = t1f;
    raw[SRC_SPI]   = spi_pend;
    raw[SRC_UART]  = uart_send_done_i | uart_recv_full_i;
    raw[SRC_T2]    = t2ovf | t2cap;
    raw[SRC_UART2] = uart2_send_done_i | uart2_recv_full_i;
  end

  // Enabled requests and the running level go to the arbiter.
  assign arb.req = raw & src_enable_i & {NSRC{global_enable_i}};
  assign arb.hi  = src_prio_hi_i;
  assign arb.cur = in_service_o[2] ? LVL_PSM  :
                   in_service_o[1] ? LVL_HIGH :
                   in_service_o[0] ? LVL_LOW  : LVL_NONE;

  ifvu_arbiter u_arb (
    .bus (arb)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      blocked <= FLAG_RST;
    end else if (return_from_isr_i || prio_en_access_i || state == ST_LOAD) begin
      blocked <= 1'b1;
    end else if (inst_done_i) begin
      blocked <= 1'b0;
    end
  end

  // Cycles a winner has waited; restarts whenever the winner goes away.
  // It stops at the maximum, so a return in the forcing cycle only defers the vector one clock.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      lat_cnt <= LAT_RST;
    end else if (state != ST_IDLE || !arb.win_vld) begin
      lat_cnt <= LAT_RST;
    end else if (lat_cnt < 8'(LAT_MAX_CYC)) begin
      lat_cnt <= lat_cnt + 8'h01;
    end
  end

  // forced at maximum
  // The maximum wins over the block; only a return in the same cycle still defers the vector.
  assign go = (state == ST_IDLE) && arb.win_vld && !return_from_isr_i &&
              (lat_cnt >= 8'(LAT_MIN_CYC)) &&
              ((inst_done_i && !blocked) || (lat_cnt >= 8'(LAT_MAX_CYC)));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state      <= ST_IDLE;
      idx_q      <= 4'h0;
      push_pc_o  <= 1'b0;
      load_pc_o  <= 1'b0;
      vec_addr_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            state     <= ST_PUSH;
            idx_q     <= arb.win_idx;
            push_pc_o <= 1'b1;
          end
        end
        ST_PUSH: begin
          state      <= ST_LOAD;
          push_pc_o  <= 1'b0;
          load_pc_o  <= 1'b1;
          vec_addr_o <= VEC_ADDR[idx_q];
        end
        ST_LOAD: begin
          state     <= ST_IDLE;
          load_pc_o <= 1'b0;
        end
        default: begin
          state     <= ST_IDLE;
          push_pc_o <= 1'b0;
          load_pc_o <= 1'b0;
        end
      endcase
    end
  end

  for (genvar g = 0; g < STK_D; g++) begin : g_stack
    always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
        stack[g] <= '0;
      end else if (go && sp == 2'(g)) begin
        stack[g] <= pc_i;
      end
    end
  end

  assign top_pc = (sp == SP_RST) ? stack[0] : stack[sp - 2'h1];

  // Stack pointer, in-service levels and the return path.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sp           <= SP_RST;
      in_service_o <= '0;
      pop_pc_o     <= 1'b0;
      pc_ret_o     <= '0;
    end else begin
      pop_pc_o <= 1'b0;
      if (go) begin
        sp <= sp + 2'h1;
        in_service_o[arb.win_lvl - LVL_LOW] <= 1'b1;
      end else if (return_from_isr_i && sp != SP_RST) begin
        sp       <= sp - 2'h1;
        pop_pc_o <= 1'b1;
        pc_ret_o <= top_pc;
        if (in_service_o[2]) begin
          in_service_o[2] <= 1'b0;
        end else if (in_service_o[1]) begin
          in_service_o[1] <= 1'b0;
        end else begin
          in_service_o[0] <= 1'b0;
        end
      end
    end
  end

  // Byte views of the flags; unused bits read as zero.
  always_comb begin
    timer_ctrl_reg_o                 = '0;
    timer_ctrl_reg_o[TIMER_CTRL_REG_EXT0_BIT]  = ext0_flag;
    timer_ctrl_reg_o[TIMER_CTRL_REG_EXT1_BIT]  = ext1_flag;
    timer_ctrl_reg_o[TIMER_CTRL_REG_T0_BIT]    = t0f;
    timer_ctrl_reg_o[TIMER_CTRL_REG_T1_BIT]    = t1f;
    timer2_ctrl_reg_o                = '0;
    timer2_ctrl_reg_o[T2_OVF_BIT]    = t2ovf;
    timer2_ctrl_reg_o[T2_CAP_BIT]    = t2cap;
    rtc_ctrl_reg_o                   = '0;
    rtc_ctrl_reg_o[RTC_ALM_BIT]      = alm;
    rtc_ctrl_reg_o[RTC_INT_BIT]      = itv;
    energy_status_low_o              = '0;
    energy_status_low_o[ENERGY_BIT]  = enf;
    power_flag_reg_o                 = '0;
    power_flag_reg_o[POWER_BIT]      = psf;
    watchdog_ctrl_reg_o              = '0;
    watchdog_ctrl_reg_o[WDT_BIT]     = wdf;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_push_load;
    push_pc_o && !load_pc_o ##1 load_pc_o && !push_pc_o;
  endsequence

  a_push_then_load: assert property ($rose(push_pc_o) |-> s_push_load)
    else $error("Vector load did not follow PC push.");
  a_vec_addr_ok: assert property (load_pc_o |-> vec_addr_o == VEC_ADDR[idx_q])
    else $error("Wrong vector address.");
  a_rtc_not_cleared: assert property (
    state == ST_LOAD && idx_q == 4'(SRC_RTC) && (alm || itv) && rtc_ctrl_clr_i == 8'h00
    |=> alm || itv)
    else $error("Vectoring cleared the RTC request.");
  a_temp_latched: assert property (
    temp_pend && !ack[SRC_TEMP] |=> temp_pend)
    else $error("Temperature request lost before its routine.");
  a_t2_kept: assert property (
    state == ST_LOAD && idx_q == 4'(SRC_T2) && (t2ovf || t2cap) && timer2_ctrl_clr_i == 8'h00
    |=> t2ovf || t2cap)
    else $error("Timer 2 flag cleared by vectoring.");
  a_t0_autoclear: assert property (
    ack[SRC_T0] && !timer0_ovf_i |=> !t0f)
    else $error("Timer 0 flag not cleared by vectoring.");
  a_lat_min: assert property ($rose(push_pc_o) |-> $past(lat_cnt) >= 8'(LAT_MIN_CYC))
    else $error("Vectored before minimum latency.");
  a_lat_max: assert property (lat_cnt <= 8'(LAT_MAX_CYC))
    else $error("Latency exceeded its maximum.");
  a_no_back_vector: assert property (
    blocked && !inst_done_i && lat_cnt < 8'(LAT_MAX_CYC) |=> !push_pc_o)
    else $error("Vectored without an instruction in between.");
  a_psm_wins: assert property (arb.req[SRC_PSM] && arb.win_vld |->
    arb.win_idx == 4'(SRC_PSM))
    else $error("Power request lost arbitration.");
  a_pop_restores: assert property (
    return_from_isr_i && !go && sp != SP_RST |=> pop_pc_o && pc_ret_o == $past(top_pc))
    else $error("Return did not restore the saved PC.");
endmodule : ifvu_top

// ---- ifvu_pkg.sv ----
// Shared constants and types of the interrupt flag and vector unit.
package ifvu_pkg;
  // Sources, numbered in polling order; index 0 wins among equal levels.
  localparam int NSRC      = 13;
  localparam int SRC_PSM   = 0;
  localparam int SRC_RTC   = 1;
  localparam int SRC_EN    = 2;
  localparam int SRC_WDT   = 3;
  localparam int SRC_TEMP  = 4;
  localparam int SRC_EXT0  = 5;
  localparam int SRC_T0    = 6;
  localparam int SRC_EXT1  = 7;
  localparam int SRC_T1    = 8;
  localparam int SRC_SPI   = 9;
  localparam int SRC_UART  = 10;
  localparam int SRC_T2    = 11;
  localparam int SRC_UART2 = 12;

  // Vector addresses, indexed by polling order.
  localparam int PC_W = 16;
  localparam logic [PC_W-1:0] VEC_ADDR [NSRC] = '{
    16'h0043, 16'h0053, 16'h004B, 16'h005B, 16'h0033, 16'h0003, 16'h000B,
    16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0063};

  // Flag bit positions inside the byte views.
  localparam int TIMER_CTRL_REG_EXT0_BIT = 1;
  localparam int TIMER_CTRL_REG_EXT1_BIT = 3;
  localparam int TIMER_CTRL_REG_T0_BIT   = 5;
  localparam int TIMER_CTRL_REG_T1_BIT   = 7;
  localparam int T2_OVF_BIT    = 7;
  localparam int T2_CAP_BIT    = 6;
  localparam int RTC_ALM_BIT   = 6;
  localparam int RTC_INT_BIT   = 2;
  localparam int ENERGY_BIT    = 7;
  localparam int POWER_BIT     = 6;
  localparam int WDT_BIT       = 2;

  // Latency limits, as times and as clock counts.
  localparam int CLK_PERIOD_NS = 25;
  localparam int LAT_MIN_NS    = 800;
  localparam int LAT_MAX_NS    = 4000;
  localparam int LAT_MIN_CYC   = (LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LAT_MAX_CYC   = LAT_MAX_NS / CLK_PERIOD_NS;

  // Saved-PC stack, one entry per priority level.
  localparam int STK_D = 3;

  // Values after reset.
  localparam logic       FLAG_RST = 1'b0;
  localparam logic       PIN_RST  = 1'b1;
  localparam logic [7:0] LAT_RST  = 8'h00;
  localparam logic [1:0] SP_RST   = 2'h0;

  typedef enum logic [1:0] {LVL_NONE, LVL_LOW, LVL_HIGH, LVL_PSM} ifvu_lvl_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_LOAD} ifvu_state_t;
endpackage : ifvu_pkg

// ---- ifvu_arb_if.sv ----
// Request and winner signals between the controller and its arbiter.
`timescale 1ns/10ps
interface ifvu_arb_if;
  import ifvu_pkg::*;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] hi;
  ifvu_lvl_t       cur;
  logic            win_vld;
  logic [3:0]      win_idx;
  ifvu_lvl_t       win_lvl;
  modport ctrl (output req, hi, cur, input win_vld, win_idx, win_lvl);
  modport arb  (input req, hi, cur, output win_vld, win_idx, win_lvl);
endinterface : ifvu_arb_if

// ---- ifvu_arbiter.sv ----
// Level and polling-order arbiter over all interrupt requests.
`timescale 1ns/10ps
module ifvu_arbiter import ifvu_pkg::*; (
  ifvu_arb_if.arb bus // Requests in, winner out.
);
  // Scan from lowest polling rank upward so the best rank wins ties.
  always_comb begin
    ifvu_lvl_t  lv;
    ifvu_lvl_t  best;
    logic [3:0] idx;
    lv   = LVL_NONE;
    best = LVL_NONE;
    idx  = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      lv = (i == SRC_PSM) ? LVL_PSM : (bus.hi[i] ? LVL_HIGH : LVL_LOW);
      if (bus.req[i] && (lv >= best)) begin
        best = lv;
        idx  = 4'(i);
      end
    end
    bus.win_lvl = best;
    bus.win_idx = idx;
    bus.win_vld = (best != LVL_NONE) && (best > bus.cur);
  end
endmodule : ifvu_arbiter

// ---- ifvu_ext_unit.sv ----
// External pin interrupt flag with edge or level trigger and wake pending.
`timescale 1ns/10ps
module ifvu_ext_unit import ifvu_pkg::*; (
  input  wire logic clk_sys_i,  // System clock.
  input  wire logic resetn_i,   // Synchronous reset, active low.
  input  wire logic pin_n_i,    // External pin, active low, asynchronous.
  input  wire logic edge_sel_i, // 1 selects falling edge, 0 low level.
  input  wire logic shutdown_i, // Core shut down.
  input  wire logic wake_i,     // Wake-up event pulse.
  input  wire logic ack_i,      // Vector taken for this source.
  input  wire logic sw_clr_i,   // Software clears the flag.
  output logic      flag_o,     // Request flag.
  output logic      req_o       // Request towards the arbiter.
);
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic wake_pend;
  logic fall;

  // Two-stage synchroniser for the asynchronous pin.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_meta <= PIN_RST;
      pin_sync <= PIN_RST;
    end else begin
      pin_meta <= pin_n_i;
      pin_sync <= pin_meta;
    end
  end

  // Previous sample, kept current even in shutdown so no stale edge fires.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_prev <= PIN_RST;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  assign fall = pin_prev & ~pin_sync;

  // Flag update; a new edge wins over a clear in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      flag_o <= FLAG_RST;
    end else if (shutdown_i) begin
      flag_o <= flag_o;
    end else if (edge_sel_i) begin
      flag_o <= fall | (flag_o & ~(ack_i | sw_clr_i));
    end else begin
      flag_o <= ~pin_sync;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wake_pend <= FLAG_RST;
    end else begin
      wake_pend <= (wake_i & shutdown_i) | (wake_pend & ~ack_i);
    end
  end

  assign req_o = flag_o | wake_pend;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_shut_hold: assert property (shutdown_i |=> flag_o == $past(flag_o))
    else $error("External flag changed during shutdown.");
  a_wake_pending: assert property (shutdown_i && wake_i |=> req_o [*1])
    else $error("Wake event left no pending request.");
  a_edge_clear: assert property (
    edge_sel_i && !shutdown_i && ack_i && !fall |=> !flag_o)
    else $error("Edge flag not cleared by vector.");
  a_level_keep: assert property (
    !edge_sel_i && !shutdown_i && !pin_sync |=> flag_o)
    else $error("Level flag dropped while pin low.");
endmodule : ifvu_ext_unit

// ---- ifvu_core_model.sv ----
// Core-side model: instruction boundaries and returns from service routines.
`timescale 1ns/10ps
module ifvu_core_model (
  input  wire logic       clk_sys_i,        // System clock.
  input  wire logic       resetn_i,         // Synchronous reset, active low.
  input  wire logic       load_pc_i,        // Vector loaded into the PC.
  input  wire logic [2:0] in_service_i,     // Levels in service.
  output logic            inst_done_o,      // Instruction boundary pulse.
  output logic            return_from_isr_o // Return instruction pulse.
);
  logic [1:0] step    = 2'h0;
  logic [4:0] isr_len = 5'h00;
  initial {inst_done_o, return_from_isr_o} = 2'h0;
  // One instruction every four clocks; a routine returns after twenty clocks.
  // routine saves registers
  // routine reads status
  // The routine reads the whole combined serial status itself to learn why it was called.
  // The routine keeps its own accumulator and status word, so only the PC is at stake.
  always @(negedge clk_sys_i) begin
    step <= resetn_i ? step + 2'h1 : 2'h0;
    inst_done_o <= resetn_i && (step == 2'h3);
    return_from_isr_o <= resetn_i && (isr_len == 5'h13);
    if (!resetn_i || load_pc_i || isr_len == 5'h13) begin
      isr_len <= 5'h00;
    end else if (|in_service_i) begin
      isr_len <= isr_len + 5'h01;
    end
  end
endmodule : ifvu_core_model

// ---- test_interrupt_flag_vector_unit.sv ----
// Self-checking bench for the interrupt flag and vector unit.
`timescale 1ns/10ps
module test_interrupt_flag_vector_unit import ifvu_pkg::*; ;
  logic clk_sys_i = 0, resetn_i = 0, ext_pin0_n_i = 1, ext_pin1_n_i = 1;
  logic ext0_edge_select_i = 1, ext1_edge_select_i = 1, core_shutdown_mode_i = 0;
  logic ext0_wake_i = 0, ext1_wake_i = 0, timer0_ovf_i = 0, timer1_ovf_i = 0;
  logic timer2_ovf_i = 0, timer2_cap_i = 0, power_evt_i = 0, energy_evt_i = 0;
  logic rtc_alarm_i = 0, rtc_interval_i = 0, watchdog_evt_i = 0, temp_evt_i = 0;
  logic spi_i2c_evt_i = 0, uart_send_done_i = 0, uart_recv_full_i = 0;
  logic uart2_send_done_i = 0, uart2_recv_full_i = 0, energy_clr_i = 0, power_clr_i = 0;
  logic watchdog_clr_i = 0, global_enable_i = 1, prio_en_access_i = 0;
  logic inst_done_i, return_from_isr_i, push_pc_o, load_pc_o, pop_pc_o;
  logic [7:0] timer_ctrl_clr_i = 0, timer2_ctrl_clr_i = 0, rtc_ctrl_clr_i = 0;
  logic [NSRC-1:0] src_enable_i = 0, src_prio_hi_i = 0;
  logic [PC_W-1:0] pc_i = 16'h1234, vec_addr_o, pc_ret_o;
  logic [7:0] timer_ctrl_reg_o, timer2_ctrl_reg_o, rtc_ctrl_reg_o, energy_status_low_o;
  logic [7:0] power_flag_reg_o, watchdog_ctrl_reg_o;
  logic [2:0] in_service_o;
  int mismatches = 0, n_compared = 0;
  ifvu_top dut (.*);
  ifvu_core_model core (.clk_sys_i, .resetn_i, .load_pc_i(load_pc_o),
    .in_service_i(in_service_o), .inst_done_o(inst_done_i),
    .return_from_isr_o(return_from_isr_i));
  // Free-running 40 MHz clock.
  always #12.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick
  // Bounded wait on a design pulse; the count is the number of clocks taken.
  task automatic wait_for(ref logic sig, output int n);
    n = 0;
    while (sig !== 1'b1) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > 400) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask : wait_for
  // One-clock high pulse on a bench-driven input, from one falling edge to the next.
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // Enables one source, checks push, load, vector, latency and level, then the return.
  task automatic serve(input int src, input logic [15:0] vec, input logic [2:0] lvl);
    int n;
    int m;
    pc_i = ~vec;
    src_enable_i[src] = 1'b1;
    wait_for(push_pc_o, n);
    wait_for(load_pc_o, m);
    chk("push to load", 16'(m), 16'h0001);
    chk("vector", vec_addr_o, vec);
    chk("min latency", 16'(n >= LAT_MIN_CYC), 16'h0001);
    chk("max latency", 16'(n <= LAT_MAX_CYC + 4), 16'h0001);
    chk("in service", 16'(in_service_o), 16'(lvl));
    tick(1);
    src_enable_i = '0;
    wait_for(pop_pc_o, n);
    chk("return pc", pc_ret_o, ~vec);
    chk("level released", 16'(in_service_o), 16'h0000);
    tick(1);
  endtask : serve
  // Timer 0 after an enable access; vectoring clears its flag.
  task automatic sc_timer0;
    pulse(prio_en_access_i);
    pulse(timer0_ovf_i);
    serve(SRC_T0, 16'h000B, 3'h1);
    chk("timer0 flag", 16'(timer_ctrl_reg_o), 16'h0000);
  endtask : sc_timer0
  // Both timer 2 causes share one vector and survive it until software clears them.
  task automatic sc_timer2;
    timer2_cap_i = 1'b1;
    pulse(timer2_ovf_i);
    timer2_cap_i = 1'b0;
    serve(SRC_T2, 16'h002B, 3'h1);
    chk("timer2 flags", 16'(timer2_ctrl_reg_o), 16'h00C0);
    timer2_ctrl_clr_i = 8'hC0;
    tick(1);
    timer2_ctrl_clr_i = 8'h00;
    chk("timer2 cleared", 16'(timer2_ctrl_reg_o), 16'h0000);
  endtask : sc_timer2
  // RTC alarm and interval flags stay through the vector and go on a software clear.
  task automatic sc_rtc;
    rtc_alarm_i = 1'b1;
    pulse(rtc_interval_i);
    rtc_alarm_i = 1'b0;
    serve(SRC_RTC, 16'h0053, 3'h1);
    chk("rtc flags kept", 16'(rtc_ctrl_reg_o), 16'h0044);
    rtc_ctrl_clr_i = 8'h44;
    tick(1);
    rtc_ctrl_clr_i = 8'h00;
    tick(1);
    chk("rtc flags cleared", 16'(rtc_ctrl_reg_o), 16'h0000);
  endtask : sc_rtc
  // Falling edge on pin 0; the vector clears the edge flag.
  task automatic sc_ext0;
    ext_pin0_n_i = 1'b0;
    tick(4);
    ext_pin0_n_i = 1'b1;
    serve(SRC_EXT0, 16'h0003, 3'h1);
    chk("ext0 flag", 16'(timer_ctrl_reg_o), 16'h0000);
  endtask : sc_ext0
  // Temperature and serial requests show nowhere and wait, through clears, for their routines.
  task automatic sc_hidden;
    pulse(temp_evt_i);
    pulse(spi_i2c_evt_i);
    timer_ctrl_clr_i = 8'hFF;
    tick(1);
    timer_ctrl_clr_i = 8'h00;
    chk("no hidden flag", 16'(timer_ctrl_reg_o | timer2_ctrl_reg_o | rtc_ctrl_reg_o |
        energy_status_low_o | power_flag_reg_o | watchdog_ctrl_reg_o), 16'h0000);
    tick(40);
    serve(SRC_TEMP, 16'h0033, 3'h1);
    serve(SRC_SPI, 16'h003B, 3'h1);
    src_enable_i[SRC_TEMP] = 1'b1;
    tick(40);
    chk("temp served once", 16'(in_service_o), 16'h0000);
    src_enable_i = '0;
  endtask : sc_hidden
  // Power request on its own level; then energy beats watchdog in polling order.
  task automatic sc_levels;
    pulse(power_evt_i);
    serve(SRC_PSM, 16'h0043, 3'h4);
    chk("power flag", 16'(power_flag_reg_o), 16'h0040);
    energy_evt_i = 1'b1;
    watchdog_evt_i = 1'b1;
    pulse(power_clr_i);
    energy_evt_i = 1'b0;
    watchdog_evt_i = 1'b0;
    chk("power cleared", 16'(power_flag_reg_o), 16'h0000);
    src_enable_i[SRC_WDT] = 1'b1;
    serve(SRC_EN, 16'h004B, 3'h1);
    chk("energy bit", 16'(energy_status_low_o), 16'h0080);
    chk("watchdog flag", 16'(watchdog_ctrl_reg_o), 16'h0004);
    energy_clr_i = 1'b1;
    pulse(watchdog_clr_i);
    energy_clr_i = 1'b0;
    chk("energy cleared", 16'(energy_status_low_o | watchdog_ctrl_reg_o), 16'h0000);
  endtask : sc_levels
  // Pin activity in shutdown leaves the flag alone; the wake event still gets served.
  task automatic sc_wake;
    core_shutdown_mode_i = 1'b1;
    ext_pin1_n_i = 1'b0;
    tick(4);
    ext_pin1_n_i = 1'b1;
    tick(3);
    chk("shutdown ext flag", 16'(timer_ctrl_reg_o), 16'h0000);
    pulse(ext1_wake_i);
    core_shutdown_mode_i = 1'b0;
    serve(SRC_EXT1, 16'h0013, 3'h1);
    chk("wake flag", 16'(timer_ctrl_reg_o), 16'h0000);
  endtask : sc_wake
  // Low-level pin 0 is served again while it stays low.
  task automatic sc_level;
    ext0_edge_select_i = 1'b0;
    ext_pin0_n_i = 1'b0;
    tick(3);
    serve(SRC_EXT0, 16'h0003, 3'h1);
    chk("level flag kept", 16'(timer_ctrl_reg_o), 16'h0002);
    serve(SRC_EXT0, 16'h0003, 3'h1);
    ext_pin0_n_i = 1'b1;
    tick(3);
    chk("level flag gone", 16'(timer_ctrl_reg_o), 16'h0000);
    ext0_edge_select_i = 1'b1;
  endtask : sc_level
  // Main sequence: every scenario in turn after reset.
  initial begin
    tick(6);
    resetn_i = 1;
    tick(2);
    sc_timer0();
    sc_timer2();
    sc_rtc();
    sc_ext0();
    sc_hidden();
    sc_levels();
    sc_wake();
    sc_level();
    report_and_stop();
  end
endmodule : test_interrupt_flag_vector_unit
